// [hdl/rtcc_regs.vh]
`ifndef RTCC_REGS_VH
`define RTCC_REGS_VH

// Register addresses on the special-function-register bus.
`define RTCC_ADDR_SET_CMP_LOW   8'hA1
`define RTCC_ADDR_SET_CMP_HIGH  8'hA2
`define RTCC_ADDR_CLR_CMP_LOW   8'hA3
`define RTCC_ADDR_CLR_CMP_HIGH  8'hA4
`define RTCC_ADDR_SET_MASK      8'hA5
`define RTCC_ADDR_CLR_MASK      8'hA6
`define RTCC_ADDR_IRQ_ENABLE_B  8'hB8
`define RTCC_ADDR_IRQ_REQUEST   8'hC0
`define RTCC_ADDR_TIMER_CTRL    8'hC8
`define RTCC_ADDR_RELOAD_LOW    8'hCA
`define RTCC_ADDR_RELOAD_HIGH   8'hCB
`define RTCC_ADDR_COUNT_LOW     8'hCC
`define RTCC_ADDR_COUNT_HIGH    8'hCD

// Field positions in the timer control register.
`define RTCC_CTRL_INSEL_LO      0
`define RTCC_CTRL_INSEL_HI      1
`define RTCC_CTRL_RLD_LO        2
`define RTCC_CTRL_RLD_HI        3
`define RTCC_CTRL_PS_LO         4
`define RTCC_CTRL_PS_HI         5
`define RTCC_CTRL_CMP_EN        6

// Field positions in the interrupt request and enable registers.
`define RTCC_IRQ_OVF_BIT        6
`define RTCC_IRQ_EXT_BIT        7
`define RTCC_IEN_TIMER_BIT      0
`define RTCC_IEN_EXTRLD_BIT     1

// Input select encodings.
`define RTCC_IN_STOP            2'h0
`define RTCC_IN_TIMER           2'h1
`define RTCC_IN_EVENT           2'h2
`define RTCC_IN_GATED           2'h3

// Reset values and the all-ones count.
`define RTCC_RST_BYTE           8'h00
`define RTCC_RST_WORD           16'h0000
`define RTCC_COUNT_ALL_ONES     16'hFFFF

`endif

// [hdl/rtcc_edge_sync.v]
module rtcc_edge_sync (
   input  wire i_core_clk,
   input  wire i_reset,
   input  wire i_pin,
   output wire o_level,
   output wire o_fall
);

   reg meta;
   reg sample;
   reg sample_prev;

   // Two flip-flops bring the pin into the clock domain, a third holds
   // the previous machine-cycle sample for edge recognition.
   always @(posedge i_core_clk) begin
      if (i_reset) begin
         meta        <= 1'b0;
         sample      <= 1'b0;
         sample_prev <= 1'b0;
      end else begin
         meta        <= i_pin;
         sample      <= meta;
         sample_prev <= sample;
      end
   end

   assign o_level = sample;
   assign o_fall  = sample_prev & ~sample;

endmodule

// [hdl/rtcc_timer.v]
// How it works
// - Timer function counts every 1, 2, 4 or 8 machine cycles by prescaler.
// - Count is 16 bits, low and high byte, advancing at most once a cycle.
// - Gated timer counts only while the gate pin samples high.
// - Gate pin is sampled once every machine cycle.
// - Event counter increments when count pin samples high then low.
// - The incremented count appears the cycle after edge detection.
// - Edge recognition spans two cycles, so events count at most every two.
// - Rollover from all ones to zero sets overflow flag, bit 6.
// - Both flags share one interrupt; hardware never clears them.
// - Reload mode: high bit zero off, 10 overflow, 11 reload-pin edge.
// - Input select: 00 stop, 01 timer, 10 event, 11 gated timer.
// - Overflow reload loads the reload value in the same cycle as the flag.
// - Reload-pin falling edge copies reload value into the count.
// - Reload-pin edge sets external reload flag only when enabled.
// - With timer interrupt enabled, a set external flag raises a request.
// - Reload pin sampled each cycle; reload follows the detecting cycle.
// - Reload register has separate low and high bytes.
// - Count low and high bytes are separately readable and writable.
// - Count equal to set compare drives masked port pins high.
// - Count equal to clear compare drives masked port pins low.
// - Compare values are 16-bit and masks PORT_WIDTH-bit registers, all resetting to zero.
`include "rtcc_regs.vh"

module rtcc_timer #(
   parameter PORT_WIDTH = 8
) (
   input  wire                  i_core_clk,
   input  wire                  i_reset,
   input  wire [7:0]            i_sfr_addr,
   input  wire                  i_sfr_wr,
   input  wire [7:0]            i_sfr_wdata,
   input  wire                  i_sfr_rd,
   output reg  [7:0]            o_sfr_rdata,
   input  wire                  i_gate_count_pin,
   input  wire                  i_ext_reload_pin,
   output reg  [PORT_WIDTH-1:0] o_port,
   output reg                   o_irq
);

   reg  [15:0]           count;
   reg  [15:0]           reload_value;
   reg  [15:0]           set_compare_value;
   reg  [15:0]           clear_compare_value;
   reg  [PORT_WIDTH-1:0] output_set_mask;
   reg  [PORT_WIDTH-1:0] output_clear_mask;
   reg  [1:0]            input_select;
   reg  [1:0]            reload_mode;
   reg  [1:0]            prescale_select;
   reg                   compare_enable;
   reg                   overflow_flag;
   reg                   ext_reload_flag;
   reg                   timer_irq_enable;
   reg                   ext_reload_enable;
   reg  [2:0]            prescale_count;
   reg                   ext_edge_seen;
   reg                   count_updated;

   reg  [15:0]           next_count;
   reg                   next_updated;
   reg                   count_tick;
   reg                   prescale_done;
   reg  [7:0]            next_rdata;

   wire [PORT_WIDTH-1:0] next_port;
   wire                  gate_level;
   wire                  count_fall;
   wire                  reload_fall;
   wire                  rollover;
   wire                  wr_count_low;
   wire                  wr_count_high;
   wire                  ovf_reload_mode;
   wire                  ext_reload_mode;
   wire                  pin_reload;
   wire                  set_match;
   wire                  clear_match;
   wire                  flag_write;
   wire                  ext_flag_set;
   wire                  flag_pending;

   rtcc_edge_sync u_gate_count_sync (
      .i_core_clk (i_core_clk),
      .i_reset    (i_reset),
      .i_pin      (i_gate_count_pin),
      .o_level    (gate_level),
      .o_fall     (count_fall)
   );

   // Only the falling edge of the reload pin is used, never its level.
   rtcc_edge_sync u_ext_reload_sync (
      .i_core_clk (i_core_clk),
      .i_reset    (i_reset),
      .i_pin      (i_ext_reload_pin),
      .o_level    (),
      .o_fall     (reload_fall)
   );

   assign wr_count_low    = i_sfr_wr & (i_sfr_addr == `RTCC_ADDR_COUNT_LOW);
   assign wr_count_high   = i_sfr_wr & (i_sfr_addr == `RTCC_ADDR_COUNT_HIGH);
   assign ovf_reload_mode = reload_mode[1] & ~reload_mode[0];
   assign ext_reload_mode = reload_mode[1] & reload_mode[0];
   assign pin_reload      = ext_edge_seen & ext_reload_mode;
   assign flag_write      = i_sfr_wr &
                            (i_sfr_addr == `RTCC_ADDR_IRQ_REQUEST);

   // A reload-pin fall flags an interrupt whenever enabled, in any mode.
   assign ext_flag_set    = reload_fall & ext_reload_enable;
   assign flag_pending    = overflow_flag | ext_reload_flag;

   // The prescaler ends a period every 1, 2, 4 or 8 machine cycles.
   always @* begin
      case (prescale_select)
         2'h0: prescale_done = 1'b1;
         2'h1: prescale_done = prescale_count[0];
         2'h2: prescale_done = &prescale_count[1:0];
         2'h3: prescale_done = &prescale_count;
         default: prescale_done = 1'b1;
      endcase
   end

   always @(posedge i_core_clk) begin
      if (i_reset) begin
         prescale_count <= 3'h0;
      end else begin
         prescale_count <= prescale_count + 3'h1;
      end
   end

   // Selects whether the counter advances in this machine cycle.
   always @* begin
      case (input_select)
         `RTCC_IN_STOP:  count_tick = 1'b0;
         `RTCC_IN_TIMER: count_tick = prescale_done;
         `RTCC_IN_EVENT: count_tick = count_fall;
         `RTCC_IN_GATED: count_tick = prescale_done & gate_level;
         default:        count_tick = 1'b0;
      endcase
   end

   // A pin reload replaces the advance of that cycle, so it is no rollover.
   assign rollover = count_tick & ~pin_reload &
                     (count == `RTCC_COUNT_ALL_ONES);

   // Next count: software write, then pin reload, then the advance.
   always @* begin
      next_count   = count;
      next_updated = 1'b0;
      if (pin_reload) begin
         next_count   = reload_value;
         next_updated = 1'b1;
      end else if (count_tick) begin
         next_updated = 1'b1;
         if (rollover && ovf_reload_mode) begin
            next_count = reload_value;
         end else begin
            next_count = count + 16'h0001;
         end
      end
      if (wr_count_low) begin
         next_count[7:0] = i_sfr_wdata;
         next_updated    = 1'b1;
      end
      if (wr_count_high) begin
         next_count[15:8] = i_sfr_wdata;
         next_updated     = 1'b1;
      end
   end

   always @(posedge i_core_clk) begin
      if (i_reset) begin
         count         <= `RTCC_RST_WORD;
         count_updated <= 1'b0;
         ext_edge_seen <= 1'b0;
      end else begin
         count         <= next_count;
         count_updated <= next_updated;
         ext_edge_seen <= reload_fall;
      end
   end

   // Register writes from the special-function-register bus.
   always @(posedge i_core_clk) begin
      if (i_reset) begin
         reload_value        <= `RTCC_RST_WORD;
         set_compare_value   <= `RTCC_RST_WORD;
         clear_compare_value <= `RTCC_RST_WORD;
         output_set_mask     <= {PORT_WIDTH{1'b0}};
         output_clear_mask   <= {PORT_WIDTH{1'b0}};
         input_select        <= `RTCC_IN_STOP;
         reload_mode         <= 2'h0;
         prescale_select     <= 2'h0;
         compare_enable      <= 1'b0;
         timer_irq_enable    <= 1'b0;
         ext_reload_enable   <= 1'b0;
      end else if (i_sfr_wr) begin
         case (i_sfr_addr)
            `RTCC_ADDR_RELOAD_LOW:   reload_value[7:0]  <= i_sfr_wdata;
            `RTCC_ADDR_RELOAD_HIGH:  reload_value[15:8] <= i_sfr_wdata;
            `RTCC_ADDR_SET_CMP_LOW:  set_compare_value[7:0] <= i_sfr_wdata;
            `RTCC_ADDR_SET_CMP_HIGH: set_compare_value[15:8] <= i_sfr_wdata;
            `RTCC_ADDR_CLR_CMP_LOW:  clear_compare_value[7:0] <= i_sfr_wdata;
            `RTCC_ADDR_CLR_CMP_HIGH: begin
               clear_compare_value[15:8] <= i_sfr_wdata;
            end
            `RTCC_ADDR_SET_MASK: begin
               output_set_mask <= i_sfr_wdata[PORT_WIDTH-1:0];
            end
            `RTCC_ADDR_CLR_MASK: begin
               output_clear_mask <= i_sfr_wdata[PORT_WIDTH-1:0];
            end
            `RTCC_ADDR_TIMER_CTRL: begin
               input_select    <= i_sfr_wdata[`RTCC_CTRL_INSEL_HI:
                                              `RTCC_CTRL_INSEL_LO];
               reload_mode     <= i_sfr_wdata[`RTCC_CTRL_RLD_HI:
                                              `RTCC_CTRL_RLD_LO];
               prescale_select <= i_sfr_wdata[`RTCC_CTRL_PS_HI:
                                              `RTCC_CTRL_PS_LO];
               compare_enable  <= i_sfr_wdata[`RTCC_CTRL_CMP_EN];
            end
            `RTCC_ADDR_IRQ_ENABLE_B: begin
               timer_irq_enable  <= i_sfr_wdata[`RTCC_IEN_TIMER_BIT];
               ext_reload_enable <= i_sfr_wdata[`RTCC_IEN_EXTRLD_BIT];
            end
            default: begin
               reload_value <= reload_value;
            end
         endcase
      end
   end

   // Both flags are cleared only by software; a hardware set wins.
   always @(posedge i_core_clk) begin
      if (i_reset) begin
         overflow_flag   <= 1'b0;
         ext_reload_flag <= 1'b0;
      end else begin
         if (flag_write) begin
            overflow_flag   <= i_sfr_wdata[`RTCC_IRQ_OVF_BIT];
            ext_reload_flag <= i_sfr_wdata[`RTCC_IRQ_EXT_BIT];
         end
         if (rollover) begin
            overflow_flag <= 1'b1;
         end
         if (ext_flag_set) begin
            ext_reload_flag <= 1'b1;
         end
      end
   end

   // One shared request line for both flags.
   always @(posedge i_core_clk) begin
      if (i_reset) begin
         o_irq <= 1'b0;
      end else begin
         o_irq <= timer_irq_enable & flag_pending;
      end
   end

   // Compares look at the count only in the cycle after it changed.
   assign set_match   = compare_enable & count_updated &
                        (count == set_compare_value);
   assign clear_match = compare_enable & count_updated &
                        (count == clear_compare_value);

   // Concurrent compare per pin; a clear match beats a set match.
   genvar bit_index;
   generate
      for (bit_index = 0; bit_index < PORT_WIDTH;
           bit_index = bit_index + 1) begin : g_port_bit
         reg port_bit;
         always @* begin
            port_bit = o_port[bit_index];
            if (set_match && output_set_mask[bit_index]) begin
               port_bit = 1'b1;
            end
            if (clear_match && output_clear_mask[bit_index]) begin
               port_bit = 1'b0;
            end
         end
         assign next_port[bit_index] = port_bit;
      end
   endgenerate

   always @(posedge i_core_clk) begin
      if (i_reset) begin
         o_port <= {PORT_WIDTH{1'b0}};
      end else begin
         o_port <= next_port;
      end
   end

   // Register readback; unmapped addresses read zero.
   always @* begin
      next_rdata = 8'h00;
      case (i_sfr_addr)
         `RTCC_ADDR_COUNT_LOW:    next_rdata = count[7:0];
         `RTCC_ADDR_COUNT_HIGH:   next_rdata = count[15:8];
         `RTCC_ADDR_RELOAD_LOW:   next_rdata = reload_value[7:0];
         `RTCC_ADDR_RELOAD_HIGH:  next_rdata = reload_value[15:8];
         `RTCC_ADDR_SET_CMP_LOW:  next_rdata = set_compare_value[7:0];
         `RTCC_ADDR_SET_CMP_HIGH: next_rdata = set_compare_value[15:8];
         `RTCC_ADDR_CLR_CMP_LOW:  next_rdata = clear_compare_value[7:0];
         `RTCC_ADDR_CLR_CMP_HIGH: next_rdata = clear_compare_value[15:8];
         `RTCC_ADDR_SET_MASK: begin
            next_rdata[PORT_WIDTH-1:0] = output_set_mask;
         end
         `RTCC_ADDR_CLR_MASK: begin
            next_rdata[PORT_WIDTH-1:0] = output_clear_mask;
         end
         `RTCC_ADDR_TIMER_CTRL: begin
            next_rdata[`RTCC_CTRL_INSEL_HI:`RTCC_CTRL_INSEL_LO] = input_select;
            next_rdata[`RTCC_CTRL_RLD_HI:`RTCC_CTRL_RLD_LO] = reload_mode;
            next_rdata[`RTCC_CTRL_PS_HI:`RTCC_CTRL_PS_LO] = prescale_select;
            next_rdata[`RTCC_CTRL_CMP_EN] = compare_enable;
         end
         `RTCC_ADDR_IRQ_ENABLE_B: begin
            next_rdata[`RTCC_IEN_TIMER_BIT]  = timer_irq_enable;
            next_rdata[`RTCC_IEN_EXTRLD_BIT] = ext_reload_enable;
         end
         `RTCC_ADDR_IRQ_REQUEST: begin
            next_rdata[`RTCC_IRQ_OVF_BIT] = overflow_flag;
            next_rdata[`RTCC_IRQ_EXT_BIT] = ext_reload_flag;
         end
         default: next_rdata = 8'h00;
      endcase
   end

   always @(posedge i_core_clk) begin
      if (i_reset) begin
         o_sfr_rdata <= 8'h00;
      end else if (i_sfr_rd) begin
         o_sfr_rdata <= next_rdata;
      end
   end

endmodule

// [verification/rtcc_checker.sv]
`include "rtcc_regs.vh"
module rtcc_checker #(
   parameter PORT_WIDTH = 8
) (
   input wire                  i_core_clk,
   input wire                  i_reset,
   input wire [7:0]            i_sfr_addr,
   input wire                  i_sfr_wr,
   input wire [7:0]            i_sfr_wdata,
   input wire                  i_sfr_rd,
   input wire [7:0]            o_sfr_rdata,
   input wire                  i_gate_count_pin,
   input wire                  i_ext_reload_pin,
   input wire [PORT_WIDTH-1:0] o_port,
   input wire                  o_irq
);
   timeunit 1ns;
   timeprecision 1ps;
   // Shadows of the plain byte registers, the timer enable and compare enable.
   reg  [7:0]            shd [0:15];
   reg  [7:0]            exp_rd;
   reg                   ien_tmr;
   reg                   cmp_on;
   wire [PORT_WIDTH-1:0] sm = shd[5][PORT_WIDTH-1:0];
   wire [PORT_WIDTH-1:0] cm = shd[6][PORT_WIDTH-1:0];
   wire                  is_sh = (i_sfr_addr >= `RTCC_ADDR_SET_CMP_LOW &&
      i_sfr_addr <= `RTCC_ADDR_CLR_MASK) ||
      i_sfr_addr == `RTCC_ADDR_RELOAD_LOW ||
      i_sfr_addr == `RTCC_ADDR_RELOAD_HIGH;
   always @(posedge i_core_clk) begin
      if (i_reset) begin
         for (int i = 0; i < 16; i++) shd[i] <= 8'h00;
         exp_rd  <= 8'h00;
         ien_tmr <= 1'b0;
         cmp_on  <= 1'b0;
      end else begin
         exp_rd <= shd[i_sfr_addr[3:0]];
         if (i_sfr_wr && is_sh) shd[i_sfr_addr[3:0]] <= i_sfr_wdata;
         if (i_sfr_wr && i_sfr_addr == `RTCC_ADDR_IRQ_ENABLE_B)
            ien_tmr <= i_sfr_wdata[0];
         if (i_sfr_wr && i_sfr_addr == `RTCC_ADDR_TIMER_CTRL)
            cmp_on <= i_sfr_wdata[6];
      end
   end
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (i_reset);
   a_reset_quiet: assert property (disable iff (1'b0)
      i_reset |=> o_port == '0 && !o_irq && o_sfr_rdata == 8'h00)
      else $error("outputs not cleared by reset");
   a_plain_readback: assert property (
      i_sfr_rd && is_sh |=> o_sfr_rdata == exp_rd)
      else $error("register readback differs from written value");
   a_unmapped_zero: assert property (
      i_sfr_rd && i_sfr_addr < 8'hA0 |=> o_sfr_rdata == 8'h00)
      else $error("unmapped read not zero");
   a_rdata_holds: assert property (
      !i_sfr_rd |=> $stable(o_sfr_rdata))
      else $error("read data changed without a read");
   a_irq_masked: assert property (
      !ien_tmr && !$past(ien_tmr) |-> !o_irq)
      else $error("interrupt raised while disabled");
   a_irq_from_flag: assert property (
      i_sfr_wr && i_sfr_addr == `RTCC_ADDR_IRQ_REQUEST && i_sfr_wdata[6]
      ##1 ien_tmr && !i_sfr_wr |=> o_irq)
      else $error("pending overflow flag gave no interrupt");
   a_port_rise_masked: assert property (
      !$past(i_reset) |-> (o_port & ~$past(o_port) & ~(sm | $past(sm))) == '0)
      else $error("port pin set outside set mask");
   a_port_fall_masked: assert property (
      !$past(i_reset) |-> (~o_port & $past(o_port) & ~(cm | $past(cm))) == '0)
      else $error("port pin cleared outside clear mask");
   a_port_hold_off: assert property (
      !$past(i_reset) && !cmp_on && !$past(cmp_on) |-> $stable(o_port))
      else $error("port moved with compare disabled");
endmodule

bind rtcc_timer rtcc_checker #(.PORT_WIDTH(PORT_WIDTH)) i_checker (
   .i_core_clk       (i_core_clk),
   .i_reset          (i_reset),
   .i_sfr_addr       (i_sfr_addr),
   .i_sfr_wr         (i_sfr_wr),
   .i_sfr_wdata      (i_sfr_wdata),
   .i_sfr_rd         (i_sfr_rd),
   .o_sfr_rdata      (o_sfr_rdata),
   .i_gate_count_pin (i_gate_count_pin),
   .i_ext_reload_pin (i_ext_reload_pin),
   .o_port           (o_port),
   .o_irq            (o_irq)
);

// [verification/rtcc_pin_model.sv]
module rtcc_pin_model (
   input  wire  i_core_clk,
   output logic o_gate_count_pin,
   output logic o_ext_reload_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   // Both pins idle high, where the port pull-ups leave them.
   initial begin
      o_gate_count_pin = 1'b1;
      o_ext_reload_pin = 1'b1;
   end
   task automatic set_gate(input logic lvl);
      o_gate_count_pin = lvl;
   endtask
   // Every level is held for whole machine cycles so that it is sampled.
   task automatic count_falls(input int n, input int hold);
      repeat (n) begin
         o_gate_count_pin = 1'b0;
         repeat (hold) @(posedge i_core_clk);
         #1 o_gate_count_pin = 1'b1;
         repeat (hold) @(posedge i_core_clk);
         #1;
      end
   endtask
   task automatic reload_fall;
      o_ext_reload_pin = 1'b0;
      repeat (2) @(posedge i_core_clk);
      #1 o_ext_reload_pin = 1'b1;
   endtask
endmodule

// [verification/test_reload_timer_concurrent_compare.sv]
`include "rtcc_regs.vh"
module test_reload_timer_concurrent_compare;
   timeunit 1ns;
   timeprecision 1ps;
   logic       i_core_clk;
   logic       i_reset;
   logic [7:0] i_sfr_addr;
   logic       i_sfr_wr;
   logic [7:0] i_sfr_wdata;
   logic       i_sfr_rd;
   logic [7:0] o_sfr_rdata;
   logic       gate_pin;
   logic       reload_pin;
   logic [7:0] o_port;
   logic       o_irq;
   int         num_errors;
   int         cmp_count;
   int         seed = 32'h5894F42E;
   localparam logic [7:0] REGS [10] = '{`RTCC_ADDR_SET_CMP_LOW,
      `RTCC_ADDR_SET_CMP_HIGH, `RTCC_ADDR_CLR_CMP_LOW, `RTCC_ADDR_CLR_CMP_HIGH,
      `RTCC_ADDR_SET_MASK, `RTCC_ADDR_CLR_MASK, `RTCC_ADDR_RELOAD_LOW,
      `RTCC_ADDR_RELOAD_HIGH, `RTCC_ADDR_COUNT_LOW, `RTCC_ADDR_COUNT_HIGH};
   rtcc_timer #(.PORT_WIDTH(8)) i_dut (
      .i_core_clk       (i_core_clk),
      .i_reset          (i_reset),
      .i_sfr_addr       (i_sfr_addr),
      .i_sfr_wr         (i_sfr_wr),
      .i_sfr_wdata      (i_sfr_wdata),
      .i_sfr_rd         (i_sfr_rd),
      .o_sfr_rdata      (o_sfr_rdata),
      .i_gate_count_pin (gate_pin),
      .i_ext_reload_pin (reload_pin),
      .o_port           (o_port),
      .o_irq            (o_irq)
   );
   rtcc_pin_model i_pins (
      .i_core_clk       (i_core_clk),
      .o_gate_count_pin (gate_pin),
      .o_ext_reload_pin (reload_pin)
   );
   initial begin
      i_core_clk = 1'b0;
      forever #5 i_core_clk = ~i_core_clk;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge i_core_clk);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      i_sfr_addr  = a;
      i_sfr_wdata = d;
      i_sfr_wr    = 1'b1;
      tick(1);
      i_sfr_wr = 1'b0;
      tick(1);
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      i_sfr_addr = a;
      i_sfr_rd   = 1'b1;
      tick(1);
      i_sfr_rd = 1'b0;
      d = o_sfr_rdata;
      tick(1);
   endtask
   task automatic w16(input logic [15:0] v);
      wr(`RTCC_ADDR_COUNT_LOW, v[7:0]);
      wr(`RTCC_ADDR_COUNT_HIGH, v[15:8]);
   endtask
   task automatic rd16(output logic [15:0] v);
      rd(`RTCC_ADDR_COUNT_LOW, v[7:0]);
      rd(`RTCC_ADDR_COUNT_HIGH, v[15:8]);
   endtask
   task automatic chk(input string s, input logic [15:0] e,
                      input logic [15:0] g, input int t);
      logic [15:0] dif;
      dif = g - e + t[15:0];
      cmp_count++;
      if ((dif <= 2 * t) !== 1'b1) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial begin
      repeat (100000) @(posedge i_core_clk);
      num_errors++;
      end_of_test;
   end
   initial begin
      logic [7:0]  d;
      logic [7:0]  sm;
      logic [7:0]  cm;
      logic [7:0]  pe;
      logic [15:0] r;
      logic [15:0] v;
      int          k;
      {i_reset, i_sfr_addr, i_sfr_wr, i_sfr_wdata, i_sfr_rd} = 19'h40000;
      num_errors = 0;
      cmp_count  = 0;
      tick(16);
      i_reset = 1'b0;
      for (int i = 0; i < 10; i++) begin
         rd(REGS[i], d);
         chk("reset value", 16'h0000, {8'h00, d}, 0);
         v = $random(seed);
         wr(REGS[i], v[7:0]);
         rd(REGS[i], d);
         chk("readback", {8'h00, v[7:0]}, {8'h00, d}, 0);
      end
      wr(8'h10, 8'h5A);
      rd(8'h10, d);
      chk("unmapped", 16'h0000, {8'h00, d}, 0);
      for (int ps = 0; ps < 4; ps++) begin
         w16(16'h0000);
         wr(`RTCC_ADDR_TIMER_CTRL, {2'b00, ps[1:0], 4'h1});
         tick(62);
         wr(`RTCC_ADDR_TIMER_CTRL, 8'h00);
         rd16(v);
         chk("prescaled count", 16'(64 >> ps), v, 1);
      end
      r = $random(seed);
      r[15] = 1'b0;
      wr(`RTCC_ADDR_RELOAD_LOW, r[7:0]);
      wr(`RTCC_ADDR_RELOAD_HIGH, r[15:8]);
      wr(`RTCC_ADDR_IRQ_ENABLE_B, 8'h01);
      for (int rm = 0; rm < 4; rm++) begin
         w16(16'hFFF0);
         wr(`RTCC_ADDR_IRQ_REQUEST, 8'h00);
         wr(`RTCC_ADDR_TIMER_CTRL, {4'h0, rm[1:0], 2'b01});
         tick(30);
         wr(`RTCC_ADDR_TIMER_CTRL, 8'h00);
         chk("ovf irq", 16'h0001, {15'h0000, o_irq}, 0);
         rd(`RTCC_ADDR_IRQ_REQUEST, d);
         chk("ovf flag", 16'h0040, {8'h00, d}, 0);
         rd16(v);
         chk("rollover", (rm == 2) ? r + 16'h0010 : 16'h0010, v, 0);
      end
      wr(`RTCC_ADDR_IRQ_REQUEST, 8'h00);
      chk("irq cleared", 16'h0000, {15'h0000, o_irq}, 0);
      wr(`RTCC_ADDR_IRQ_REQUEST, 8'h40);
      chk("irq from flag", 16'h0001, {15'h0000, o_irq}, 0);
      wr(`RTCC_ADDR_IRQ_REQUEST, 8'h00);
      k = 3 + ($random(seed) & 7);
      w16(16'h0000);
      wr(`RTCC_ADDR_TIMER_CTRL, 8'h02);
      i_pins.count_falls(k, 1);
      tick(4);
      wr(`RTCC_ADDR_TIMER_CTRL, 8'h00);
      rd16(v);
      chk("event count", 16'(k), v, 0);
      i_pins.set_gate(1'b0);
      for (int g = 0; g < 2; g++) begin
         w16(16'h0000);
         wr(`RTCC_ADDR_TIMER_CTRL, 8'h03);
         tick(30);
         wr(`RTCC_ADDR_TIMER_CTRL, 8'h00);
         rd16(v);
         chk("gated count", 16'(32 * g), v, 1);
         i_pins.set_gate(1'b1);
      end
      wr(`RTCC_ADDR_TIMER_CTRL, 8'h0C);
      for (int e = 0; e < 2; e++) begin
         wr(`RTCC_ADDR_IRQ_ENABLE_B, e ? 8'h01 : 8'h03);
         w16(16'h0000);
         i_pins.reload_fall;
         tick(4);
         rd16(v);
         chk("pin reload", r, v, 0);
         rd(`RTCC_ADDR_IRQ_REQUEST, d);
         chk("ext flag", e ? 16'h0000 : 16'h0080, {8'h00, d}, 0);
         chk("ext irq", 16'(1 - e), {15'h0000, o_irq}, 0);
         wr(`RTCC_ADDR_IRQ_REQUEST, 8'h00);
      end
      pe = 8'h00;
      for (int c = 0; c < 2; c++) begin
         sm = $random(seed);
         cm = $random(seed);
         pe = (pe | sm) & ~cm;
         wr(`RTCC_ADDR_SET_CMP_LOW, c ? 8'h03 : 8'h05);
         wr(`RTCC_ADDR_SET_CMP_HIGH, 8'h00);
         wr(`RTCC_ADDR_CLR_CMP_LOW, c ? 8'h03 : 8'h0A);
         wr(`RTCC_ADDR_CLR_CMP_HIGH, 8'h00);
         wr(`RTCC_ADDR_SET_MASK, sm);
         wr(`RTCC_ADDR_CLR_MASK, cm);
         w16(16'h0000);
         wr(`RTCC_ADDR_TIMER_CTRL, 8'h41);
         tick(20);
         wr(`RTCC_ADDR_TIMER_CTRL, 8'h00);
         chk("port", {8'h00, pe}, {8'h00, o_port}, 0);
      end
      end_of_test;
   end
endmodule
